/* verilog/dac_seq_pkg.sv */
// Overview of operation
// - each input word is ten bits on one shared bus, spread over six channels
// - two latch stages per channel; all outputs change together on second-stage load
// - sequenced mode starts storing on the first selected clock edge after a start assertion
// - all first stages copy to second stages on first falling clock after transfer
// - direction low stores channels in ascending order, 0 up to 5
// - direction high stores channels in descending order, 5 down to 0
// - edge select high captures sequenced words on rising clock edges, low on falling edges
// - even/odd pair: high-select device takes even words, low-select odd words
// - direct loading stores into the addressed channel on every falling edge
// - addressed loading stores on falling edge into channel sampled on prior rise
// - after addressed loading, outputs update only on a valid transfer strobe
// - standby high clears all stored words and the sequencer and pending-transfer state
// - standby low again resumes normal loading and update
package dac_seq_pkg;
  localparam int             WORD_W      = 10;
  localparam int             CHANS       = 6;
  localparam int             CH_W        = 3;
  localparam int             BUF_W       = CH_W + WORD_W;
  localparam int             BUF_DEPTH   = 2;
  localparam int             BUF_CH_LSB  = WORD_W;
  localparam logic [2:0]     SEQ_ADDR    = 3'h7;
  localparam logic [2:0]     FIRST_CH    = 3'h0;
  localparam logic [2:0]     LAST_CH     = 3'h5;
  localparam logic [7:0]     CTRL_OFS    = 8'h00;
  localparam logic [7:0]     STATUS_OFS  = 8'h04;
  localparam logic [7:0]     OUT_BASE    = 8'h10;
  localparam logic [1:0]     CTRL_RST    = 2'h0;
  localparam logic [WORD_W-1:0] STAGE_RST = 10'h000;
  localparam int             CTRL_STANDBY_IN   = 0;
  localparam int             CTRL_HOLD   = 1;
  localparam int             ST_ACTIVE   = 0;
  localparam int             ST_CNT_LSB  = 1;
  localparam int             ST_PEND     = 4;
  localparam int             ST_OVF      = 5;
  localparam int             ST_STANDBY_IN     = 6;
endpackage

/* verilog/word_buf_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface word_buf_if;
  logic                           in_valid;
  logic                           in_ready;
  logic [dac_seq_pkg::BUF_W-1:0]  in_data;
  logic                           out_valid;
  logic                           out_ready;
  logic [dac_seq_pkg::BUF_W-1:0]  out_data;
  logic                           flush;
  modport buf_side (input in_valid, in_data, out_ready, flush,
                    output in_ready, out_valid, out_data);
  modport user_side (output in_valid, in_data, out_ready, flush,
                     input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

/* verilog/word_buf.sv */
`timescale 1ns/1ps
`default_nettype none
module word_buf #(
  parameter int WIDTH = dac_seq_pkg::BUF_W,
  parameter int DEPTH = dac_seq_pkg::BUF_DEPTH
) (
  input wire logic      i_clk,  // system clock
  input wire logic      i_rstn, // async reset, active low
  word_buf_if.buf_side  bus     // fill and drain sides
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [PW:0]                 cnt;
  } buf_st_t;

  buf_st_t s;
  buf_st_t next_s;
  logic    push;
  logic    pop;

  assign bus.in_ready  = (s.cnt != (PW+1)'(DEPTH));
  assign bus.out_valid = (s.cnt != '0);
  assign bus.out_data  = s.mem[s.rd];

  always_comb
  begin
    next_s = s;
    push   = bus.in_valid & bus.in_ready;
    pop    = bus.out_valid & bus.out_ready;
    if (push)
    begin
      next_s.mem[s.wr] = bus.in_data;
      next_s.wr = (s.wr == PW'(DEPTH - 1)) ? '0 : PW'(s.wr + 1'b1);
    end
    if (pop)
      next_s.rd = (s.rd == PW'(DEPTH - 1)) ? '0 : PW'(s.rd + 1'b1);
    if (push && !pop)
      next_s.cnt = (PW+1)'(s.cnt + 1'b1);
    else if (pop && !push)
      next_s.cnt = (PW+1)'(s.cnt - 1'b1);
    if (bus.flush)
      next_s = '0;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      s <= '0;
    else
      s <= next_s;
  end
endmodule
`default_nettype wire

/* verilog/dac_load_seq.sv */
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dac_load_seq (
  input  wire logic        i_clk,             // system clock, 10 MHz
  input  wire logic        i_rstn,            // async reset, active low
  input  wire logic        i_pix_clk,         // partner word clock
  input  wire logic [9:0]  i_video_word,      // shared video word
  input  wire logic        i_start_sequence,  // start / chip select
  input  wire logic        i_transfer_strobe, // second-stage update
  input  wire logic        i_standby_in,      // standby, active high
  input  wire logic        i_load_dir,        // 0 ascending, 1 descending
  input  wire logic        i_edge_sel,        // 1 rising, 0 falling
  input  wire logic [2:0]  i_chan_addr,       // channel address
  input  wire logic        i_psel,            // apb select
  input  wire logic        i_penable,         // apb enable
  input  wire logic        i_pwrite,          // apb direction
  input  wire logic [7:0]  i_paddr,           // apb byte address
  input  wire logic [31:0] i_pwdata,          // apb write data
  output logic      [31:0] o_prdata,          // apb read data
  output logic             o_pready,          // apb ready
  output logic             o_pslverr,         // apb error
  output logic      [59:0] o_video_out        // six second-stage words
);
  typedef struct packed {
    logic                                  pclk_q;
    logic                                  start_q;
    logic                                  xfer_q;
    logic [2:0]                            addr_q;
    logic                                  seq_active;
    logic [2:0]                            seq_cnt;
    logic                                  xfer_pend;
    logic                                  copy_due;
    logic                                  overflow;
    logic [1:0]                            ctrl;
    logic [5:0][dac_seq_pkg::WORD_W-1:0]   stage1;
    logic [5:0][dac_seq_pkg::WORD_W-1:0]   stage2;
    logic [31:0]                           prdata;
    logic                                  pready;
    logic                                  pslverr;
  } seq_st_t;

  seq_st_t     s;
  seq_st_t     next_s;
  word_buf_if  wbuf ();

  logic        rise;
  logic        fall;
  logic        standby_in;
  logic        seq_mode;
  logic        direct;
  logic        start_rise;
  logic        xfer_rise;
  logic        seq_hit;
  logic [2:0]  seq_chan;
  logic        adr_hit;
  logic        push_req;
  logic [2:0]  push_chan;
  logic        copy_now;
  logic        apb_acc;
  logic        wr_go;
  logic [7:0]  out_ofs;
  logic        out_hit;
  logic        map_hit;
  logic [31:0] rd_word;

  word_buf u_buf (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .bus    (wbuf.buf_side)
  );

  assign o_prdata    = s.prdata;
  assign o_pready    = s.pready;
  assign o_pslverr   = s.pslverr;
  assign o_video_out = s.stage2;

  // edge and mode decode
  always_comb
  begin
    rise       = i_pix_clk & ~s.pclk_q;
    fall       = ~i_pix_clk & s.pclk_q;
    standby_in       = i_standby_in | s.ctrl[dac_seq_pkg::CTRL_STANDBY_IN];
    seq_mode   = (i_chan_addr == dac_seq_pkg::SEQ_ADDR);
    direct     = ~seq_mode & i_start_sequence & i_transfer_strobe;
    start_rise = i_start_sequence & ~s.start_q;
    xfer_rise  = i_transfer_strobe & ~s.xfer_q;
    // even words on rises, odd words on falls
    seq_hit    = seq_mode & s.seq_active
                 & (i_edge_sel ? rise : fall);
    seq_chan   = i_load_dir
                 ? 3'(dac_seq_pkg::LAST_CH - s.seq_cnt)
                 : s.seq_cnt;
    adr_hit    = ~seq_mode & fall
                 & (s.addr_q <= dac_seq_pkg::LAST_CH);
    push_req   = ~standby_in & (seq_hit | adr_hit);
    push_chan  = seq_hit ? seq_chan : s.addr_q;
    // wait until buffered words reach the first stage
    copy_now   = s.copy_due & ~wbuf.out_valid & ~push_req;
  end

  assign wbuf.in_valid  = push_req;
  assign wbuf.in_data   = {push_chan, i_video_word};
  assign wbuf.out_ready = ~s.ctrl[dac_seq_pkg::CTRL_HOLD];
  assign wbuf.flush     = standby_in;

  // apb decode and read mux
  always_comb
  begin
    apb_acc = i_psel & i_penable;
    wr_go   = apb_acc & s.pready & i_pwrite;
    out_ofs = 8'(i_paddr - dac_seq_pkg::OUT_BASE);
    out_hit = (out_ofs[7:5] == 3'h0) && (out_ofs[1:0] == 2'h0)
              && (out_ofs[4:2] <= dac_seq_pkg::LAST_CH);
    map_hit = out_hit || (i_paddr == dac_seq_pkg::CTRL_OFS)
              || (i_paddr == dac_seq_pkg::STATUS_OFS);
    rd_word = 32'h0000_0000;
    if (i_paddr == dac_seq_pkg::CTRL_OFS)
      rd_word[1:0] = s.ctrl;
    else if (i_paddr == dac_seq_pkg::STATUS_OFS)
    begin
      rd_word[dac_seq_pkg::ST_ACTIVE]       = s.seq_active;
      rd_word[dac_seq_pkg::ST_CNT_LSB +: 3] = s.seq_cnt;
      rd_word[dac_seq_pkg::ST_PEND]         = s.xfer_pend | s.copy_due;
      rd_word[dac_seq_pkg::ST_OVF]          = s.overflow;
      rd_word[dac_seq_pkg::ST_STANDBY_IN]         = standby_in;
    end
    else if (out_hit)
      rd_word[dac_seq_pkg::WORD_W-1:0] = s.stage2[out_ofs[4:2]];
  end

  // next state
  always_comb
  begin
    next_s         = s;
    next_s.pclk_q  = i_pix_clk;
    next_s.start_q = i_start_sequence;
    next_s.xfer_q  = i_transfer_strobe;
    if (rise)
      next_s.addr_q = i_chan_addr;
    if (seq_hit)
    begin
      next_s.seq_cnt = 3'(s.seq_cnt + 3'h1);
      if (s.seq_cnt == dac_seq_pkg::LAST_CH)
        next_s.seq_active = 1'b0;
    end
    if (start_rise && seq_mode)
    begin
      next_s.seq_active = 1'b1;
      next_s.seq_cnt    = dac_seq_pkg::FIRST_CH;
    end
    if (fall && (s.xfer_pend || direct))
    begin
      next_s.copy_due  = 1'b1;
      next_s.xfer_pend = 1'b0;
    end
    if (xfer_rise && !direct)
      next_s.xfer_pend = 1'b1;
    if (copy_now)
    begin
      next_s.stage2   = s.stage1;
      next_s.copy_due = 1'b0;
    end
    if (wbuf.out_valid && wbuf.out_ready)
      next_s.stage1[wbuf.out_data[dac_seq_pkg::BUF_CH_LSB +: 3]] =
        wbuf.out_data[dac_seq_pkg::WORD_W-1:0];
    if (wr_go && i_paddr == dac_seq_pkg::CTRL_OFS)
      next_s.ctrl = i_pwdata[1:0];
    if (wr_go && i_paddr == dac_seq_pkg::STATUS_OFS
        && i_pwdata[dac_seq_pkg::ST_OVF])
      next_s.overflow = 1'b0;
    // set beats clear
    if (push_req && !wbuf.in_ready)
      next_s.overflow = 1'b1;
    next_s.pready  = apb_acc & ~s.pready;
    next_s.pslverr = apb_acc & ~s.pready & ~map_hit;
    if (apb_acc && !s.pready)
      next_s.prdata = rd_word;
    if (standby_in)
    begin
      next_s.stage1     = '0;
      next_s.stage2     = '0;
      next_s.seq_active = 1'b0;
      next_s.seq_cnt    = dac_seq_pkg::FIRST_CH;
      next_s.xfer_pend  = 1'b0;
      next_s.copy_due   = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s        <= '0;
      s.ctrl   <= dac_seq_pkg::CTRL_RST;
    end
    else
      s <= next_s;
  end

  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence start_armed;
    start_rise && seq_mode && !standby_in;
  endsequence

  sequence seq_ready;
    s.seq_active && (s.seq_cnt == dac_seq_pkg::FIRST_CH);
  endsequence

  sequence strobe_seen;
    xfer_rise && !direct && !standby_in;
  endsequence

  sequence first_fall;
    fall && !standby_in;
  endsequence

  property start_p;
    start_armed |=> seq_ready;
  endproperty

  property copy_p;
    copy_now && !standby_in |=> (o_video_out == $past(s.stage1));
  endproperty

  seq_start_a: assert property (start_p)
    else $error("sequencer not armed after start");

  copy_out_a: assert property (copy_p)
    else $error("outputs differ from first stage after copy");

  xfer_fall_a: assert property (strobe_seen ##1 first_fall ##0 !s.copy_due
                                |=> s.copy_due)
    else $error("transfer not armed on next falling edge");

  hold_out_a: assert property (!copy_now && !standby_in
                               |=> $stable(s.stage2))
    else $error("outputs changed without a transfer");

  asc_order_a: assert property (seq_hit && !i_load_dir && !standby_in
                                |-> push_chan == s.seq_cnt)
    else $error("ascending channel order broken");

  desc_order_a: assert property (seq_hit && i_load_dir && !standby_in
                                 |-> push_chan ==
                                 3'(dac_seq_pkg::LAST_CH - s.seq_cnt))
    else $error("descending channel order broken");

  edge_pick_a: assert property (push_req && seq_mode
                                |-> (i_edge_sel ? rise : fall))
    else $error("word captured on wrong clock edge");

  addr_fall_a: assert property (push_req && !seq_mode
                                |-> fall && push_chan == s.addr_q)
    else $error("addressed word not taken at sampled channel");

  direct_load_a: assert property (direct && fall && !standby_in
                                  |=> s.copy_due)
    else $error("direct load did not schedule update");

  seq_stop_a: assert property (seq_hit && !standby_in
                               && s.seq_cnt == dac_seq_pkg::LAST_CH
                               && !start_rise
                               |=> !s.seq_active ##0 !seq_hit)
    else $error("sequencer kept storing after six words");

  standby_in_clear_a: assert property (standby_in |=> s.stage1 == '0
                                 && s.stage2 == '0
                                 && !s.seq_active)
    else $error("standby left stored words");

  resume_a: assert property ($fell(standby_in) ##0 start_armed
                             |=> s.seq_active)
    else $error("no resume after standby");

  xfer_pend_a: assert property (strobe_seen |=> s.xfer_pend)
    else $error("transfer strobe not held pending");

  seq_count_a: assert property (seq_hit
                                |-> s.seq_cnt <= dac_seq_pkg::LAST_CH)
    else $error("sequencer count past last channel");

  standby_in_block_a: assert property (standby_in |-> !wbuf.in_valid)
    else $error("word accepted during standby");

  chan_range_a: assert property (wbuf.out_valid |->
    wbuf.out_data[dac_seq_pkg::BUF_CH_LSB +: 3] <= dac_seq_pkg::LAST_CH)
    else $error("buffered word has no valid channel");

  direct_store_a: assert property (direct && fall && !standby_in
                                   && s.addr_q <= dac_seq_pkg::LAST_CH
                                   |-> push_req && push_chan == s.addr_q)
    else $error("direct word not stored at addressed channel");

  copy_wait_a: assert property (s.copy_due && wbuf.out_valid && !standby_in
                                |=> $stable(s.stage2))
    else $error("outputs updated before buffer drained");
endmodule
`default_nettype wire

/* bench/tctl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tctl_model (
  input  wire logic       i_clk,        // system clock
  output logic            o_pix_clk,    // word clock
  output logic      [9:0] o_video_word, // shared video word
  output logic            o_start,      // start or select
  output logic            o_xfr,        // shared transfer strobe
  output logic      [2:0] o_addr        // channel address
);
  initial
  begin
    o_pix_clk = 1'b0;
    o_video_word = 10'h000;
    o_start = 1'b0;
    o_xfr = 1'b0;
    o_addr = 3'h7;
  end
  // control levels; held static high for direct loading
  task automatic ctl(input logic s, input logic x, input logic [2:0] a);
    o_start <= s;
    o_xfr <= x;
    o_addr <= a;
  endtask
  // one word clock phase; word set well before the edge, held after it
  task automatic half(input logic [9:0] w);
    o_video_word <= w;
    repeat (2) @(posedge i_clk);
    o_pix_clk <= ~o_pix_clk;
    repeat (3) @(posedge i_clk);
  endtask
  // one clock period: even word on the rise, odd word on the fall
  task automatic pair(input logic [9:0] ev, input logic [9:0] od);
    half(ev);
    half(od);
  endtask
endmodule
`default_nettype wire

/* bench/six_channel_dac_load_sequencer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module six_channel_dac_load_sequencer_tb_top;
  logic        clk, rstn, pix, start, transfer_strobe, dir, esel, standby_in;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [2:0]  addr;
  logic [7:0]  paddr;
  logic [9:0]  word, w, a;
  logic [31:0] pwdata, prdata, r;
  logic [59:0] vout;
  logic        e;
  int          st1 [6];
  int          outm [6];
  int          err_count, n_tests, ch;
  int unsigned seed;
  tctl_model tcm (.i_clk(clk), .o_pix_clk(pix), .o_video_word(word),
    .o_start(start), .o_xfr(transfer_strobe), .o_addr(addr));
  dac_load_seq dut (.i_clk(clk), .i_rstn(rstn), .i_pix_clk(pix),
    .i_video_word(word), .i_start_sequence(start), .i_transfer_strobe(transfer_strobe),
    .i_standby_in(standby_in), .i_load_dir(dir), .i_edge_sel(esel),
    .i_chan_addr(addr), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_video_out(vout));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [9:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[9:0];
  endfunction
  function automatic logic [59:0] expv();
    logic [59:0] v;
    for (int i = 0; i < 6; i++)
      v[10*i +: 10] = outm[i][9:0];
    return v;
  endfunction
  task automatic close_out();
    if (err_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_vid(input string nm);
    n_tests++;
    if (vout !== expv())
    begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, expv(), vout);
    end
  endtask
  task automatic chk_word(input string nm, input logic [31:0] x,
                          input logic [31:0] g);
    n_tests++;
    if (g !== x)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (int i = 0; i < 20 && pready !== 1'b1; i++)
      @(posedge clk);
    if (pready !== 1'b1)
    begin
      err_count++;
      close_out();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] m,
                    input logic [31:0] x, input string nm);
    apb(1'b0, ad, 32'h0000_0000);
    chk_word(nm, x, r & m);
  endtask
  task automatic copy_all();
    for (int i = 0; i < 6; i++)
      outm[i] = st1[i];
  endtask
  initial
  begin
    {rstn, dir, esel, standby_in, psel, penable, pwrite} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    seed = 80098;
    err_count = 0;
    n_tests = 0;
    for (int i = 0; i < 6; i++)
    begin
      st1[i] = 0;
      outm[i] = 0;
    end
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk_vid("reset outputs");
    rd(dac_seq_pkg::CTRL_OFS, 32'hFFFF_FFFF, 32'h0, "ctrl reset");
    rd(dac_seq_pkg::STATUS_OFS, 32'hFFFF_FFFF, 32'h0, "status reset");
    for (int m = 0; m < 4; m++)
    begin
      dir <= m[0];
      esel <= m[1];
      tcm.ctl(1'b1, 1'b0, 3'h7);
      repeat (2) @(posedge clk);
      for (int k = 0; k < 7; k++)
      begin
        w = rnd();
        a = rnd();
        tcm.pair(w, a);
        if (k < 6)
          st1[m[0] ? 5 - k : k] = m[1] ? w : a;
      end
      chk_vid("seq before transfer");
      tcm.ctl(1'b1, 1'b1, 3'h7);
      tcm.pair(rnd(), rnd());
      copy_all();
      repeat (6) @(posedge clk);
      chk_vid("seq transfer");
      tcm.ctl(1'b0, 1'b0, 3'h7);
      @(posedge clk);
    end
    esel <= 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      ch = rnd() % 6;
      w = rnd();
      tcm.ctl(1'b1, 1'b0, ch[2:0]);
      tcm.half(rnd());
      tcm.ctl(1'b1, 1'b0, 3'h6);
      tcm.half(w);
      st1[ch] = w;
    end
    chk_vid("addressed held");
    tcm.ctl(1'b1, 1'b1, 3'h7);
    tcm.pair(rnd(), rnd());
    copy_all();
    repeat (6) @(posedge clk);
    chk_vid("addressed transfer");
    for (int n = 0; n < 6; n++)
    begin
      w = rnd();
      tcm.ctl(1'b1, 1'b1, n[2:0]);
      tcm.pair(rnd(), w);
      st1[n] = w;
      copy_all();
      repeat (6) @(posedge clk);
      chk_vid("direct");
    end
    apb(1'b1, dac_seq_pkg::OUT_BASE, 32'h0000_03FF);
    for (int n = 0; n < 6; n++)
      rd(dac_seq_pkg::OUT_BASE + 8'(4 * n), 32'h0000_03FF, outm[n], "out reg");
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk_word("unmapped err", 32'h1, {31'h0, e});
    apb(1'b1, dac_seq_pkg::CTRL_OFS, 32'h0000_0002);
    rd(dac_seq_pkg::CTRL_OFS, 32'hFFFF_FFFF, 32'h2, "ctrl hold");
    tcm.ctl(1'b1, 1'b1, 3'h0);
    repeat (3) tcm.pair(rnd(), rnd());
    rd(dac_seq_pkg::STATUS_OFS, 32'h20, 32'h20, "overflow");
    apb(1'b1, dac_seq_pkg::CTRL_OFS, 32'h0000_0000);
    standby_in <= 1'b1;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 6; i++)
    begin
      st1[i] = 0;
      outm[i] = 0;
    end
    chk_vid("standby clear");
    rd(dac_seq_pkg::STATUS_OFS, 32'h40, 32'h40, "standby flag");
    standby_in <= 1'b0;
    apb(1'b1, dac_seq_pkg::STATUS_OFS, 32'h0000_0020);
    rd(dac_seq_pkg::STATUS_OFS, 32'h20, 32'h0, "overflow clear");
    w = rnd();
    tcm.ctl(1'b1, 1'b1, 3'h3);
    tcm.pair(rnd(), w);
    st1[3] = w;
    copy_all();
    repeat (6) @(posedge clk);
    chk_vid("resume");
    apb(1'b1, dac_seq_pkg::CTRL_OFS, 32'h0000_0001);
    rd(dac_seq_pkg::STATUS_OFS, 32'h40, 32'h40, "soft standby");
    for (int i = 0; i < 6; i++)
    begin
      st1[i] = 0;
      outm[i] = 0;
    end
    chk_vid("soft standby clear");
    close_out();
  end
endmodule
`default_nettype wire
